// [rtl/pst_regs.svh]
// Notes on behaviour
// (RULE_01) lanes 2 and 3 take a static 64-bit alignment marker value each
// (RULE_02) receive test enable makes the receiver expect scrambled idle; third priority
// (RULE_03) transmit test enable at 1 sends scrambled idle pattern; third priority
// (RULE_04) fifo error goes 1 on clock compensation fifo under or overflow
// (RULE_05) software resets the port after seeing fifo error
// (RULE_06) local fault is 1 while receive decoder sits in its initial state
// (RULE_07) high error rate is 1 while measured error rate is over limit
// (RULE_08) high error rate output feeds management bit 3.32.1
// (RULE_09) four block lock bits, one per lane, level while locked
// (RULE_10) block lock vector feeds lane lock management bits
// (RULE_11) eight-bit mismatch count per cycle, zero means none
// (RULE_12) mismatch count only active while receive test enable is 1
// (RULE_13) each non-zero mismatch count lasts exactly one cycle
// (RULE_14) management may accumulate counts into a 16-bit error counter
// (RULE_15) lane markers change only while the direction reset is asserted
// (RULE_16) receive and transmit status logic use their own synchronous resets
// (RULE_17) during a direction reset all its status and pulse outputs are zero; the code clears them a cycle later and sets local fault to 1
`ifndef PST_REGS_SVH
`define PST_REGS_SVH
`define PST_ADDR_CTRL     12'h000
`define PST_ADDR_STATUS   12'h004
`define PST_ADDR_ISR      12'h008
`define PST_ADDR_IMR      12'h00C
`define PST_ADDR_ERRCNT   12'h010
`define PST_CTRL_RXTEST   0
`define PST_CTRL_TXTEST   1
`define PST_ISR_FIFO      0
`define PST_ISR_HIBER     1
`define PST_ISR_LFAULT    2
`define PST_ISR_MISM      3
`define PST_ERR_THRESH    8'h10
`define PST_ERR_WINDOW    16'h0400
`endif

// [rtl/pst_pkg.sv]
`include "pst_regs.svh"
package pst_pkg;
  typedef enum logic [1:0] {
    PST_DEC_INIT = 2'b01,
    PST_DEC_RUN  = 2'b10
  } pst_dec_e;
  typedef struct packed {
    logic [1:0]  ctrl;
    logic [3:0]  isr;
    logic [3:0]  imr;
    logic [15:0] errcnt;
    logic [31:0] prdata;
    pst_dec_e    dec;
    logic        fifo_err;
    logic        hiber;
    logic [15:0] win_cnt;
    logic [7:0]  win_err;
    logic [3:0]  lock;
    logic [7:0]  mism;
    logic [65:0] tx_blk;
    logic [1:0]  tx_lane;
  } pst_state_s;
endpackage : pst_pkg

// [rtl/pst_top.sv]
// The address map and the APB slave port were left to the implementer.
`include "pst_regs.svh"
module pst_top
  import pst_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic        rx_reset,
  input  wire logic        tx_reset,
  input  wire logic [63:0] tx_lane2_align_marker,
  input  wire logic [63:0] tx_lane3_align_marker,
  input  wire logic [3:0]  rx_lane_sync_ok,
  input  wire logic [3:0]  rx_lane_hdr_err,
  input  wire logic        rx_fifo_over,
  input  wire logic        rx_fifo_under,
  input  wire logic [7:0]  rx_pattern_miss,
  output logic      [65:0] tx_marker_block,
  output logic      [1:0]  tx_marker_lane,
  output logic             tx_test_idle,
  output logic             rx_test_idle,
  output logic             rx_fifo_error,
  output logic             rx_local_fault,
  output logic             rx_high_error_rate,
  output logic      [3:0]  rx_block_lock,
  output logic      [7:0]  rx_error_incr
);
  pst_state_s s_q;
  pst_state_s s_d;
  logic       acc;
  logic       wr;
  logic       mapped;
  logic [3:0] ev;
  logic [2:0] herr;
  always_comb begin
    acc    = psel & penable;
    wr     = acc & pwrite;
    mapped = (paddr == `PST_ADDR_CTRL) | (paddr == `PST_ADDR_STATUS) | (paddr == `PST_ADDR_ISR) |
             (paddr == `PST_ADDR_IMR) | (paddr == `PST_ADDR_ERRCNT);
    herr   = 3'(rx_lane_hdr_err[0]) + 3'(rx_lane_hdr_err[1]) + 3'(rx_lane_hdr_err[2]) +
             3'(rx_lane_hdr_err[3]);
    s_d    = s_q;
    ev     = 4'h0;
    if (wr && paddr == `PST_ADDR_CTRL) begin
      s_d.ctrl = pwdata[1:0];
    end
    if (wr && paddr == `PST_ADDR_IMR) begin
      s_d.imr = pwdata[3:0];
    end
    if (wr && paddr == `PST_ADDR_ERRCNT) begin
      s_d.errcnt = 16'h0000;
    end
    // receive side, synchronous reset of its own
    if (rx_reset) begin
      s_d.dec      = PST_DEC_INIT; // RULE_16 RULE_17
      s_d.fifo_err = 1'b0;
      s_d.hiber    = 1'b0;
      s_d.win_cnt  = 16'h0000;
      s_d.win_err  = 8'h00;
      s_d.lock     = 4'h0;
      s_d.mism     = 8'h00;
    end else begin
      s_d.lock = rx_lane_sync_ok; // RULE_09 RULE_10
      // sticky until the port is reset: the fifo state is unknown once it slipped
      if (rx_fifo_over | rx_fifo_under) begin
        s_d.fifo_err = 1'b1; // RULE_04 RULE_05
      end
      unique case (s_q.dec)
        PST_DEC_INIT: if (&rx_lane_sync_ok && !s_q.hiber) s_d.dec = PST_DEC_RUN; // RULE_06
        PST_DEC_RUN:  if (!(&rx_lane_sync_ok) || s_q.hiber) s_d.dec = PST_DEC_INIT; // RULE_06
      endcase
      // windowed header error count stands in for the standard ber monitor
      s_d.win_err = (s_q.win_err == 8'hFF) ? 8'hFF : s_q.win_err + 8'(herr);
      s_d.win_cnt = s_q.win_cnt + 16'h0001;
      if (s_q.win_cnt == `PST_ERR_WINDOW) begin
        s_d.hiber   = (s_q.win_err >= `PST_ERR_THRESH); // RULE_07 RULE_08
        s_d.win_cnt = 16'h0000;
        s_d.win_err = 8'h00;
      end
      // one-cycle increment, gated by the receive test enable
      s_d.mism = s_q.ctrl[`PST_CTRL_RXTEST] ? rx_pattern_miss : 8'h00; // RULE_02 RULE_11 RULE_12 RULE_13
      if (s_q.mism != 8'h00) begin
        s_d.errcnt = (s_q.errcnt == 16'hFFFF) ? 16'hFFFF : s_q.errcnt + 16'(s_q.mism); // RULE_14
      end
      // rising edges for fifo, high error rate and fault, so a write-one-to-clear is not undone by a level that still stands; mismatch sets on every non-zero count
      ev = {s_q.mism != 8'h00, s_d.dec == PST_DEC_INIT && s_q.dec != PST_DEC_INIT, s_d.hiber & ~s_q.hiber,
            s_d.fifo_err & ~s_q.fifo_err};
    end
    // transmit side: markers must only move under reset, so they are sampled freely
    if (tx_reset) begin
      s_d.tx_blk  = 66'h0; // RULE_16 RULE_17
      s_d.tx_lane = 2'b00;
    end else begin
      s_d.tx_lane = s_q.tx_lane + 2'b01;
      // block is paired with the lane number shown beside it: lane 2 even, lane 3 odd
      s_d.tx_blk  = {2'b10, (s_d.tx_lane[0] ? tx_lane3_align_marker : tx_lane2_align_marker)}; // RULE_01 RULE_15
    end
    // set wins over write-one-to-clear
    if (wr && paddr == `PST_ADDR_ISR) begin
      s_d.isr = s_q.isr & ~pwdata[3:0];
    end
    s_d.isr = s_d.isr | ev;
    if (acc && !pwrite) begin
      unique case (paddr)
        `PST_ADDR_CTRL:   s_d.prdata = {30'h0, s_q.ctrl};
        `PST_ADDR_STATUS: s_d.prdata = {24'h0, s_q.lock, s_q.dec == PST_DEC_INIT, s_q.hiber, 1'b0, s_q.fifo_err};
        `PST_ADDR_ISR:    s_d.prdata = {28'h0, s_q.isr};
        `PST_ADDR_IMR:    s_d.prdata = {28'h0, s_q.imr};
        `PST_ADDR_ERRCNT: s_d.prdata = {16'h0, s_q.errcnt};
        default:          s_d.prdata = 32'h0;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{ctrl: 2'b00, isr: 4'h0, imr: 4'h0, errcnt: 16'h0, prdata: 32'h0, dec: PST_DEC_INIT,
               fifo_err: 1'b0, hiber: 1'b0, win_cnt: 16'h0, win_err: 8'h0, lock: 4'h0, mism: 8'h0,
               tx_blk: 66'h0, tx_lane: 2'b00};
    end else if (ce) begin
      s_q <= s_d;
    end
  end
  // read data is registered at the access edge, so the slave takes one wait state
  logic rd_done_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_done_q <= 1'b0;
    end else if (ce) begin
      rd_done_q <= acc & ~pwrite & ~rd_done_q;
    end
  end
  always_comb begin
    pready  = acc & (pwrite | rd_done_q) & ce;
    pslverr = pready & ~mapped;
    prdata  = s_q.prdata;
  end
  assign irq                = |(s_q.isr & s_q.imr);
  assign tx_marker_block    = s_q.tx_blk;
  assign tx_marker_lane     = s_q.tx_lane;
  assign tx_test_idle       = s_q.ctrl[`PST_CTRL_TXTEST] & ~tx_reset; // RULE_03
  assign rx_test_idle       = s_q.ctrl[`PST_CTRL_RXTEST] & ~rx_reset; // RULE_02
  assign rx_fifo_error      = s_q.fifo_err;
  assign rx_local_fault     = s_q.dec == PST_DEC_INIT; // RULE_06
  assign rx_high_error_rate = s_q.hiber; // RULE_07
  assign rx_block_lock      = s_q.lock;
  assign rx_error_incr      = s_q.mism; // RULE_13
endmodule : pst_top

// [dv/pst_top_monitor.sv]
module pst_top_monitor
  import pst_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        rx_reset,
  input wire logic        tx_reset,
  input wire logic        rx_fifo_over,
  input wire logic        rx_fifo_under,
  input wire logic [7:0]  rx_pattern_miss,
  input wire logic [3:0]  rx_lane_sync_ok,
  input wire logic        rx_test_idle,
  input wire logic        tx_test_idle,
  input wire logic        rx_fifo_error,
  input wire logic        rx_local_fault,
  input wire logic [3:0]  rx_block_lock,
  input wire logic [7:0]  rx_error_incr,
  input wire logic [63:0] tx_lane2_align_marker,
  input wire logic [63:0] tx_lane3_align_marker,
  input wire logic [65:0] tx_marker_block,
  input wire logic [1:0]  tx_marker_lane
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence fifo_evt; (rx_fifo_over || rx_fifo_under) && !rx_reset; endsequence
  gate_on_a: assert property (rx_test_idle |=> rx_error_incr == $past(rx_pattern_miss))
    else $error("incr wrong");
  gate_off_a: assert property (!rx_test_idle |=> rx_error_incr == 8'h00)
    else $error("incr not zero");
  fifo_set_a: assert property (fifo_evt |=> rx_fifo_error) else $error("fifo flag missed");
  fifo_hold_a: assert property (rx_fifo_error && !rx_reset |=> rx_fifo_error)
    else $error("fifo flag dropped");
  rst_clear_a: assert property (rx_reset |=> !rx_fifo_error && !rx_block_lock && !rx_error_incr)
    else $error("rx reset");
  fault_init_a: assert property (rx_reset |=> rx_local_fault) else $error("fault not set");
  fault_hold_a: assert property (rx_local_fault && !rx_reset && rx_block_lock != 4'hF && rx_lane_sync_ok != 4'hF
    |=> rx_local_fault) else $error("fault left early");
  lock_track_a: assert property (!rx_reset |=> rx_block_lock == $past(rx_lane_sync_ok))
    else $error("lock wrong");
  idle_off_a: assert property ((tx_reset |-> !tx_test_idle) and (rx_reset |-> !rx_test_idle))
    else $error("idle on");
  marker_two_a: assert property (tx_marker_lane == 2'b10 |-> tx_marker_block == {2'b10, tx_lane2_align_marker})
    else $error("lane two marker wrong");
  marker_three_a: assert property (tx_marker_lane == 2'b11 |-> tx_marker_block == {2'b10, tx_lane3_align_marker})
    else $error("lane three marker wrong");
endmodule : pst_top_monitor
bind pst_top pst_top_monitor u_mon(.pclk, .presetn, .rx_reset, .tx_reset, .rx_fifo_over, .rx_fifo_under,
  .rx_pattern_miss, .rx_lane_sync_ok, .rx_test_idle, .tx_test_idle, .rx_fifo_error, .rx_local_fault,
  .rx_block_lock, .rx_error_incr, .tx_lane2_align_marker, .tx_lane3_align_marker, .tx_marker_block,
  .tx_marker_lane);

// [dv/pst_far_model.sv]
module pst_far_model
  import pst_pkg::*;
(
  input  wire logic pclk,
  output logic [3:0] sok,
  output logic [3:0] hdr,
  output logic       ov,
  output logic       un,
  output logic [7:0] miss
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {sok, hdr, ov, un, miss} = '0;
  // events last one cycle; lock level persists between calls
  task automatic pulse(input logic [7:0] m, input logic o, u, h, input logic [3:0] s);
    @(posedge pclk);
    {miss, ov, un, hdr, sok} <= {m, o, u, {4{h}}, s};
    @(posedge pclk);
    {miss, ov, un, hdr} <= '0;
  endtask : pulse
endmodule : pst_far_model

// [dv/pcs_status_and_test_pattern_test.sv]
`include "pst_regs.svh"
module pcs_status_and_test_pattern_test
  import pst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] M2 = 64'h0123456789ABCDEF, M3 = 64'hFEDCBA9876543210;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_reset = 0, tx_reset = 0, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, irq, tx_test_idle, rx_test_idle, rx_fifo_error, rx_local_fault, rx_high_error_rate, ov, un;
  logic [65:0] tx_marker_block;
  logic [1:0]  tx_marker_lane;
  logic [3:0] sok, hdr, rx_block_lock;
  logic [7:0] miss, rx_error_incr;
  int errors = 0, samples_checked = 0, n;
  pst_far_model far(.pclk, .sok, .hdr, .ov, .un, .miss);
  pst_top uut(.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .rx_reset, .tx_reset, .tx_lane2_align_marker(M2), .tx_lane3_align_marker(M3), .rx_lane_sync_ok(sok),
    .rx_lane_hdr_err(hdr), .rx_fifo_over(ov), .rx_fifo_under(un), .rx_pattern_miss(miss), .tx_marker_block,
    .tx_marker_lane, .tx_test_idle, .rx_test_idle, .rx_fifo_error, .rx_local_fault, .rx_high_error_rate,
    .rx_block_lock, .rx_error_incr);
  initial forever #5 pclk = ~pclk;
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic results();
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 40);
    if (k >= 40) errors++;
    if (k >= 40) results();
    q = prdata;
    se = pslverr;
    {psel, penable} <= 2'b00;
  endtask : xfer
  // both directions together; checks test idle during reset and rx status after it, with local fault set
  task automatic dir_reset();
    @(posedge pclk);
    {rx_reset, tx_reset} <= 2'b11;
    #1 chk("test_idle", {rx_test_idle, tx_test_idle}, 0);
    @(posedge pclk);
    {rx_reset, tx_reset} <= 2'b00;
    #1 chk("rx_status", {rx_fifo_error, rx_local_fault, rx_high_error_rate, rx_block_lock}, 7'h20);
  endtask : dir_reset
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, 12'hFFC, 0);
    chk("unmapped_err", se, 1);
    chk("unmapped_data", q, 0);
    xfer(1, `PST_ADDR_CTRL, 3);
    xfer(1, `PST_ADDR_IMR, 1);
    #1 chk("test_idle", {tx_test_idle, rx_test_idle}, 2'b11);
    for (n = 0; n < 8 && tx_marker_lane !== 2'b10; n++) @(posedge pclk) #1;
    chk("marker2", {tx_marker_lane, tx_marker_block === {2'b10, M2}}, 3'b101);
    @(posedge pclk) #1 chk("marker3", {tx_marker_lane, tx_marker_block === {2'b10, M3}}, 3'b111);
    far.pulse(8'h05, 0, 0, 0, 4'h0);
    #1 chk("incr", rx_error_incr, 8'h05);
    @(posedge pclk) #1 chk("incr", rx_error_incr, 0);
    xfer(0, `PST_ADDR_ERRCNT, 0);
    chk("errcnt", q, 5);
    chk("mapped_err", se, 0);
    xfer(1, `PST_ADDR_ERRCNT, 0);
    xfer(0, `PST_ADDR_ERRCNT, 0);
    chk("errcnt_clear", q, 0);
    xfer(1, `PST_ADDR_CTRL, 2);
    far.pulse(8'h07, 0, 0, 0, 4'hF);
    #1 chk("incr", rx_error_incr, 0);
    repeat (4) @(posedge pclk);
    #1 chk("lock", {rx_block_lock, rx_local_fault}, 5'h1E);
    xfer(0, `PST_ADDR_STATUS, 0);
    chk("status", q[7:0], 8'hF0);
    $display("test status done");
    repeat (16) far.pulse(0, 0, 0, 1, 4'hF);
    for (n = 0; n < 2100 && rx_high_error_rate !== 1'b1; n++) @(posedge pclk);
    chk("hiber", rx_high_error_rate, 1);
    xfer(0, `PST_ADDR_STATUS, 0);
    chk("status_hiber", q[2], 1);
    xfer(0, `PST_ADDR_ISR, 0);
    chk("isr_events", q[3:0], 4'hE);
    chk("irq_masked", irq, 0);
    far.pulse(0, 1, 0, 0, 4'hF);
    #1 chk("fifo_error", rx_fifo_error, 1);
    repeat (2) @(posedge pclk);
    #1 chk("irq", irq, 1);
    dir_reset();
    far.pulse(0, 0, 1, 0, 4'hF);
    #1 chk("fifo_error", rx_fifo_error, 1);
    dir_reset();
    xfer(1, `PST_ADDR_ISR, 1);
    #1 chk("irq_clear", irq, 0);
    $display("test fifo done");
    results();
  end
endmodule : pcs_status_and_test_pattern_test
